/* hdl/smbr_pkg.sv */
// package: constants and types for the spi master with bus release
package smbr_pkg;
    // ****************************************************************
    // line counts and designations
    // ****************************************************************
    localparam int GP_COUNT = 9;
    localparam int IRQ_LINE = 6;
    localparam int ACK_LINE = 7;
    localparam int REQ_LINE = 8;
    localparam logic [1:0] DES_GPIO = 2'h0;
    localparam logic [1:0] DES_CS = 2'h1;
    localparam logic [1:0] DES_DED = 2'h2;
    // ****************************************************************
    // spi timing and reset values
    // ****************************************************************
    localparam int CLK_MHZ = 100;
    localparam int SCK_HALF_NS = 50;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [8:0] CS_IDLE_RST = 9'h1ff;
    localparam logic [8:0] CS_ACT_RST = 9'h000;
    localparam int DATA_W = 8;
    localparam logic ACK_ACTIVE = 1'b0;
    typedef enum logic [1:0] {
        SMBR_OWN,
        SMBR_DRAIN,
        SMBR_RELEASED
    } smbr_arb_t;
endpackage

/* hdl/smbr_sync.sv */
// module: two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module smbr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule
`default_nettype wire

/* hdl/smbr_shift.sv */
// module: spi mode 0 byte shifter with abort
`timescale 1ns/1ns
`default_nettype none
module smbr_shift #(
    parameter int W = smbr_pkg::DATA_W,
    parameter int HALF = smbr_pkg::SCK_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic abort,
    input wire logic [W-1:0] tx_data,
    input wire logic miso_s,
    output logic busy,
    output logic done,
    output logic [W-1:0] rx_data,
    output logic sck,
    output logic mosi
);
    localparam int CW = $clog2(HALF + 1);
    localparam int BW = $clog2(2 * W + 1);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [BW-1:0] edg_r, edg_nxt;
    logic [W-1:0] sh_r, sh_nxt;
    logic busy_r, busy_nxt, sck_r, sck_nxt, done_r, done_nxt;
    logic [W-1:0] rx_r, rx_nxt;
    // miso bit taken on the rise, held until the fall shifts it in
    logic smp_r, smp_nxt;
    // each half period toggles sck; sample on rise, shift on fall
    always_comb begin
        cnt_nxt = cnt_r;
        edg_nxt = edg_r;
        sh_nxt = sh_r;
        busy_nxt = busy_r;
        sck_nxt = sck_r;
        rx_nxt = rx_r;
        smp_nxt = smp_r;
        done_nxt = 1'b0;
        if (abort) begin
            busy_nxt = 1'b0;
            sck_nxt = 1'b0;
        end else if (!busy_r) begin
            if (start) begin
                busy_nxt = 1'b1;
                sh_nxt = tx_data;
                cnt_nxt = '0;
                edg_nxt = '0;
            end
        end else if (cnt_r == CW'(HALF - 1)) begin
            cnt_nxt = '0;
            edg_nxt = edg_r + 1'b1;
            sck_nxt = ~sck_r;
            // mosi must not move on the rise, the slave samples it there
            if (!sck_r) begin
                smp_nxt = miso_s;
            end else begin
                sh_nxt = {sh_r[W-2:0], smp_r};
            end
            if (edg_r == BW'(2 * W - 1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                rx_nxt = {sh_r[W-2:0], smp_r};
                sck_nxt = 1'b0;
            end
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end
    // registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            edg_r <= '0;
            sh_r <= '0;
            busy_r <= 1'b0;
            sck_r <= 1'b0;
            done_r <= 1'b0;
            rx_r <= '0;
            smp_r <= 1'b0;
        end else if (ce) begin
            smp_r <= smp_nxt;
            cnt_r <= cnt_nxt;
            edg_r <= edg_nxt;
            sh_r <= sh_nxt;
            busy_r <= busy_nxt;
            sck_r <= sck_nxt;
            done_r <= done_nxt;
            rx_r <= rx_nxt;
        end
    end
    assign busy = busy_r;
    assign done = done_r;
    assign rx_data = rx_r;
    assign sck = sck_r;
    assign mosi = sh_r[W-1];
endmodule
`default_nettype wire

/* hdl/smbr_top.sv */
// module: spi master with chip selects, gp lines and bus release
//
// Functional notes
// - nine lines: gpio, chip select or dedicated
// - chip select drives active level, else idle
// - chip select held across whole transfer
// - sixth line dedicated is slave interrupt input
// - eighth line dedicated is release request input
// - seventh line dedicated drives release acknowledge
// - finish transfer, then release bus and acknowledge on the same edge
// - host abort cancels transfer in progress
// - bus stays released while request held
// - host side enumerates as hid function
`timescale 1ns/1ns
`default_nettype none
module smbr_top #(
    parameter int N = smbr_pkg::GP_COUNT,
    parameter int W = smbr_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [2*N-1:0] gp_designation,
    input wire logic [N-1:0] cs_active_level,
    input wire logic [N-1:0] cs_idle_level,
    input wire logic [N-1:0] gpio_dir_out,
    input wire logic [N-1:0] gpio_out_value,
    output logic [N-1:0] gpio_in_value,
    input wire logic xfer_start,
    input wire logic xfer_abort,
    input wire logic [W-1:0] xfer_tx_data,
    output logic [W-1:0] xfer_rx_data,
    output logic xfer_busy,
    output logic xfer_done,
    output logic xfer_refused,
    output logic slave_irq,
    output logic bus_released,
    input wire logic hid_class_select,
    output logic hid_class_ok,
    input wire logic [N-1:0] general_purpose_line_i,
    output logic [N-1:0] general_purpose_line_o,
    output logic [N-1:0] general_purpose_line_oe,
    input wire logic miso,
    output logic sck_o,
    output logic sck_oe,
    output logic mosi_o,
    output logic mosi_oe
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [N-1:0] gp_s;
    logic miso_s;
    smbr_sync #(.W(N + 1)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({miso, general_purpose_line_i}),
        .q({miso_s, gp_s})
    );

    // decode the two designation bits of one line
    function automatic logic [1:0] des_of(input logic [2*N-1:0] d,
                                          input int i);
        des_of = d[2*i +: 2];
    endfunction

    logic ded_irq, ded_ack, ded_req, req_s;
    // dedicated functions of lines six, seven and eight
    assign ded_irq = des_of(gp_designation, smbr_pkg::IRQ_LINE)
                     == smbr_pkg::DES_DED;
    assign ded_ack = des_of(gp_designation, smbr_pkg::ACK_LINE)
                     == smbr_pkg::DES_DED;
    assign ded_req = des_of(gp_designation, smbr_pkg::REQ_LINE)
                     == smbr_pkg::DES_DED;
    assign req_s = ded_req && gp_s[smbr_pkg::REQ_LINE];

    // ****************************************************************
    // arbitration with the second master
    // ****************************************************************
    smbr_pkg::smbr_arb_t arb_r, arb_nxt;
    logic sh_busy, sh_done, sh_start;
    // a start is only taken while we own the bus and no request waits
    assign sh_start = xfer_start && !sh_busy && !req_s
                      && arb_r == smbr_pkg::SMBR_OWN;
    assign xfer_refused = xfer_start && !sh_start;
    always_comb begin
        arb_nxt = arb_r;
        case (arb_r)
            smbr_pkg::SMBR_OWN: begin
                if (req_s) begin
                    arb_nxt = smbr_pkg::SMBR_DRAIN;
                end
            end
            smbr_pkg::SMBR_DRAIN: begin
                // running byte completes or is aborted first
                if (!sh_busy) begin
                    arb_nxt = smbr_pkg::SMBR_RELEASED;
                end
            end
            smbr_pkg::SMBR_RELEASED: begin
                if (!req_s) begin
                    arb_nxt = smbr_pkg::SMBR_OWN;
                end
            end
            default: arb_nxt = smbr_pkg::SMBR_OWN;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            arb_r <= smbr_pkg::SMBR_OWN;
        end else if (ce) begin
            arb_r <= arb_nxt;
        end
    end

    // ****************************************************************
    // byte shifter
    // ****************************************************************
    logic sck_i, mosi_i;
    smbr_shift #(.W(W)) u_shift (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(sh_start),
        .abort(xfer_abort),
        .tx_data(xfer_tx_data),
        .miso_s(miso_s),
        .busy(sh_busy),
        .done(sh_done),
        .rx_data(xfer_rx_data),
        .sck(sck_i),
        .mosi(mosi_i)
    );
    assign xfer_busy = sh_busy;
    assign xfer_done = sh_done;

    // ****************************************************************
    // gp line drivers, registered
    // ****************************************************************
    logic [N-1:0] o_r, o_nxt, oe_r, oe_nxt, in_r, in_nxt;
    logic irq_r, irq_nxt, rel_r, rel_nxt, hid_r, hid_nxt;
    logic own;
    assign own = arb_nxt != smbr_pkg::SMBR_RELEASED;
    always_comb begin
        o_nxt = '0;
        oe_nxt = '0;
        in_nxt = gp_s;
        for (int i = 0; i < N; i++) begin
            case (des_of(gp_designation, i))
                smbr_pkg::DES_GPIO: begin
                    o_nxt[i] = gpio_out_value[i];
                    oe_nxt[i] = gpio_dir_out[i];
                end
                smbr_pkg::DES_CS: begin
                    // select held for the whole byte, tristate if released
                    o_nxt[i] = sh_busy || sh_start ? cs_active_level[i]
                               : cs_idle_level[i];
                    oe_nxt[i] = own;
                end
                default: begin
                    o_nxt[i] = 1'b0;
                    oe_nxt[i] = 1'b0;
                end
            endcase
        end
        // acknowledge only once the bus is really given up
        if (ded_ack) begin
            o_nxt[smbr_pkg::ACK_LINE] = own ? ~smbr_pkg::ACK_ACTIVE
                                        : smbr_pkg::ACK_ACTIVE;
            oe_nxt[smbr_pkg::ACK_LINE] = 1'b1;
        end
        irq_nxt = ded_irq && gp_s[smbr_pkg::IRQ_LINE];
        rel_nxt = !own;
        hid_nxt = hid_class_select;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            o_r <= '0;
            oe_r <= '0;
            in_r <= '0;
            irq_r <= 1'b0;
            rel_r <= 1'b0;
            hid_r <= 1'b0;
        end else if (ce) begin
            o_r <= o_nxt;
            oe_r <= oe_nxt;
            in_r <= in_nxt;
            irq_r <= irq_nxt;
            rel_r <= rel_nxt;
            hid_r <= hid_nxt;
        end
    end
    assign general_purpose_line_o = o_r;
    assign general_purpose_line_oe = oe_r;
    assign gpio_in_value = in_r;
    assign slave_irq = irq_r;
    assign bus_released = rel_r;
    assign hid_class_ok = hid_r;
    // spi pins float while the other master owns the bus
    assign sck_o = sck_i;
    assign mosi_o = mosi_i;
    assign sck_oe = !rel_r;
    assign mosi_oe = !rel_r;

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_rel_idle;
        @(posedge clk) disable iff (rst)
        rel_r |-> !sh_busy;
    endproperty
    a_rel_idle: assert property (p_rel_idle)
        else $error("bus released while transfer running");
    property p_drain_wait;
        @(posedge clk) disable iff (rst)
        (ce && arb_r == smbr_pkg::SMBR_DRAIN && sh_busy && !xfer_abort)
        |=> arb_r != smbr_pkg::SMBR_RELEASED;
    endproperty
    a_drain_wait: assert property (p_drain_wait)
        else $error("released before transfer ended");
    property p_hold;
        @(posedge clk) disable iff (rst)
        (arb_r == smbr_pkg::SMBR_RELEASED && req_s) |=>
        arb_r == smbr_pkg::SMBR_RELEASED;
    endproperty
    a_hold: assert property (p_hold)
        else $error("bus reclaimed while request held");
    property p_tristate;
        @(posedge clk) disable iff (rst)
        rel_r |-> !sck_oe && !mosi_oe;
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("spi outputs driven while released");
    property p_ack;
        @(posedge clk) disable iff (rst)
        (ce && ded_ack && arb_r == smbr_pkg::SMBR_RELEASED && req_s)
        |=> general_purpose_line_o[smbr_pkg::ACK_LINE]
            == smbr_pkg::ACK_ACTIVE;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge not asserted when released");
    property p_abort;
        @(posedge clk) disable iff (rst)
        (ce && xfer_abort) |=> !sh_busy;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort did not stop transfer");
    property p_refuse;
        @(posedge clk) disable iff (rst)
        (arb_r != smbr_pkg::SMBR_OWN) |-> !sh_start;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("transfer started without bus");
    property p_cs;
        @(posedge clk) disable iff (rst)
        (ce && sh_busy && des_of(gp_designation, 0) == smbr_pkg::DES_CS
         && $stable(cs_active_level)) |=>
        general_purpose_line_o[0] == $past(cs_active_level[0]);
    endproperty
    a_cs: assert property (p_cs)
        else $error("chip select not active during transfer");
    c_release: cover property (@(posedge clk) disable iff (rst)
        arb_r == smbr_pkg::SMBR_DRAIN ##[1:300]
        arb_r == smbr_pkg::SMBR_RELEASED);
    c_done: cover property (@(posedge clk) disable iff (rst) sh_done);
    c_resume: cover property (@(posedge clk) disable iff (rst)
        arb_r == smbr_pkg::SMBR_RELEASED ##1 arb_r == smbr_pkg::SMBR_OWN);
endmodule
`default_nettype wire

/* verif/smbr_far_model.sv */
// far side model: spi slave chip plus a second bus master
`timescale 1ns/1ns
`default_nettype none
module smbr_far_model (
    input wire logic clk,
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel,
    input wire logic ack,
    input wire logic want,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic req,
    output logic owns,
    output logic [7:0] rx_byte
);
    logic [7:0] sh;
    logic tgl = 1'b0;
    // ****************************************************************
    // slave shifter, mode 0, msb first
    // ****************************************************************
    // an unselected slave shows a toggling level, never stale data
    always @(posedge clk) tgl <= ~tgl;
    assign miso = sel ? sh[7] : tgl;
    always @(posedge sel) sh <= tx_byte;
    always @(posedge sck) if (sel) rx_byte <= {rx_byte[6:0], mosi};
    always @(negedge sck) if (sel) sh <= {sh[6:0], 1'b0};
    // ****************************************************************
    // second master
    // ****************************************************************
    // request stays up for as long as the bus is wanted
    always @(posedge clk) req <= want;
    // the bus is only taken once the acknowledge is seen
    always @(posedge clk) begin
        owns <= req && want && (ack === smbr_pkg::ACK_ACTIVE);
    end
endmodule
`default_nettype wire

/* verif/smbr_top_tb.sv */
// testbench: smbr_top against a bench model and the far side model
`timescale 1ns/1ns
`default_nettype none
module smbr_top_tb;
    localparam int N = smbr_pkg::GP_COUNT;
    logic clk, rst, start, abrt, hid_sel, want;
    logic [2*N-1:0] desig;
    logic [N-1:0] act, idle, dir, outv, gin, gp_i, gp_o, gp_oe, ext;
    logic [7:0] txd, rxd, slv_tx, slv_rx;
    logic busy, done, refused, sirq, rel, hid_ok, miso, sck, sck_oe;
    logic mosi, mosi_oe, sel, req, owns;
    logic [7:0] exp_q[$];
    int mismatches, cmp_count, cyc, n, i;
    // ****************************************************************
    // wires, design and far side
    // ****************************************************************
    // a pin shows the driver whose enable is high, else the outside
    assign gp_i = (gp_oe & gp_o) | (~gp_oe & {req, ext[7:0]});
    assign sel = (gp_i[0] === act[0]);
    smbr_top smbr_top_inst (.clk(clk), .rst(rst), .ce(1'b1),
        .gp_designation(desig), .cs_active_level(act),
        .cs_idle_level(idle), .gpio_dir_out(dir), .gpio_out_value(outv),
        .gpio_in_value(gin), .xfer_start(start), .xfer_abort(abrt),
        .xfer_tx_data(txd), .xfer_rx_data(rxd), .xfer_busy(busy),
        .xfer_done(done), .xfer_refused(refused), .slave_irq(sirq),
        .bus_released(rel), .hid_class_select(hid_sel),
        .hid_class_ok(hid_ok), .general_purpose_line_i(gp_i),
        .general_purpose_line_o(gp_o), .general_purpose_line_oe(gp_oe),
        .miso(miso), .sck_o(sck), .sck_oe(sck_oe), .mosi_o(mosi),
        .mosi_oe(mosi_oe));
    smbr_far_model smbr_far_model_inst (.clk(clk), .sck(sck & sck_oe),
        .mosi(mosi & mosi_oe), .sel(sel), .ack(gp_i[7]), .want(want),
        .tx_byte(slv_tx), .miso(miso), .req(req), .owns(owns),
        .rx_byte(slv_rx));
    // ****************************************************************
    // clock, timeout and helpers
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // a run needs about 450 cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc > 6000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // inputs always change 1 ns after the rising edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_rel(input logic v);
        n = 0;
        while (rel !== v && n < 20) begin
            step(1);
            n++;
        end
        chk(rel, v);
    endtask
    // one byte; the model queue holds what the slave will send back
    task automatic xfer();
        logic [7:0] d;
        d = 8'($urandom);
        slv_tx = 8'($urandom);
        exp_q.push_back(slv_tx);
        txd = d;
        start = 1'b1;
        step(1);
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            start = (n == 20);
            if (n == 20) begin
                #1 chk(refused, 1'b1);
            end
            if (n == 40) chk(gp_i[0], act[0]);
            if (n == 60) chk(rel, 1'b0);
            step(1);
            n++;
        end
        start = 1'b0;
        chk(n, 2 * smbr_pkg::DATA_W * smbr_pkg::SCK_HALF_CYC);
        chk(rxd, exp_q.pop_front());
        chk(slv_rx, d);
        step(2);
        chk(gp_i[0], idle[0]);
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        n = $urandom(32'h204a_4ace);
        {rst, start, abrt, hid_sel, want} = 5'h10;
        desig = {{3{smbr_pkg::DES_DED}}, {5{smbr_pkg::DES_GPIO}},
            smbr_pkg::DES_CS};
        act = 9'($urandom);
        idle = ~act;
        dir = 9'h002;
        outv = 9'h000;
        ext = 9'($urandom) & 9'h0be | {8'h00, idle[0]};
        {txd, slv_tx} = 16'h0000;
        step(12);
        rst = 1'b0;
        step(2);
        chk({rel, busy}, 2'h0);
        chk(gp_i[0], idle[0]);
        for (i = 0; i < 4; i++) begin
            outv = 9'($urandom);
            ext[2] = 1'($urandom);
            ext[6] = 1'($urandom);
            hid_sel = 1'($urandom);
            step(1);
            chk(hid_ok, hid_sel);
            step(3);
            chk({gp_oe[1], gp_i[1]}, {1'b1, outv[1]});
            chk(gin[2], ext[2]);
            chk({gp_oe[6], sirq}, {1'b0, ext[6]});
        end
        xfer();
        xfer();
        fork
            xfer();
            begin
                step(30);
                want = 1'b1;
            end
        join
        wait_rel(1'b1);
        step(2);
        chk({gp_oe[7], gp_i[7]}, {1'b1, smbr_pkg::ACK_ACTIVE});
        chk({gp_oe[0], sck_oe, mosi_oe, owns}, 4'h1);
        start = 1'b1;
        #1 chk(refused, 1'b1);
        step(1);
        start = 1'b0;
        step(50);
        chk({rel, busy}, 2'h2);
        want = 1'b0;
        wait_rel(1'b0);
        step(2);
        chk({gp_i[7], sck_oe, mosi_oe}, {~smbr_pkg::ACK_ACTIVE, 2'h3});
        slv_tx = 8'($urandom);
        start = 1'b1;
        step(1);
        start = 1'b0;
        want = 1'b1;
        step(10);
        abrt = 1'b1;
        step(1);
        abrt = 1'b0;
        wait_rel(1'b1);
        chk({busy, done}, 2'h0);
        want = 1'b0;
        wait_rel(1'b0);
        step(2);
        xfer();
        finish_test();
    end
endmodule
`default_nettype wire
